// file: sim/flag_sva.sv
// assertion checker for the status flag summary block
`timescale 1ns/1ps
`default_nettype none
module flag_sva
  import flag_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic spi_cs_n,
  input wire logic spi_so_oe,
  input wire logic int_n,
  input wire logic sw_reset_req,
  input wire logic switch_change_event,
  input wire logic supply_cross_event_b,
  input wire logic thermal_shutdown_cond,
  input wire logic overvoltage_event,
  input wire logic [EVT_W-1:0] event_status,
  input wire logic cmd_valid
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // driver enable is a plain function of the select pin
  a_oe_tracks_select: assert property (
    spi_so_oe == !spi_cs_n) else $error("output enable off select");
  a_switch_sets: assert property (
    switch_change_event |=> event_status[EB_SWITCH] && !int_n)
    else $error("switch event not latched");
  a_supply_sets: assert property (
    supply_cross_event_b |=> event_status[EB_SUPPLY_B])
    else $error("supply event not latched");
  // guarded by past reset so a level change inside reset is not seen
  a_thermal_edge: assert property (
    $past(resetn) && $changed(thermal_shutdown_cond)
    |=> event_status[EB_THERM_SHUT]) else $error("thermal edge missed");
  a_other_sets: assert property (
    overvoltage_event |=> event_status[EB_OVERVOLT])
    else $error("overvoltage not latched");
  // reset itself must leave the reset flag behind, so no disable here
  a_reset_flag: assert property (disable iff (1'b0)
    !resetn |=> event_status[EB_RESET]) else $error("reset flag low");
  a_swreset_flag: assert property (
    sw_reset_req |=> event_status[EB_RESET])
    else $error("soft reset flag low");
  a_error_pulls_irq: assert property (
    |event_status[EVT_W-1:1] |-> !int_n) else $error("irq not low");
  // a clear may only land once select has been high a while
  a_clear_after_close: assert property (
    $fell(event_status[EB_SWITCH]) |-> spi_cs_n && $past(spi_cs_n, 2))
    else $error("clear before select rose");
  a_cmd_single: assert property (
    cmd_valid |=> !cmd_valid) else $error("command pulse too long");
  a_cmd_after_close: assert property (
    cmd_valid |-> $past(spi_cs_n, 3)) else $error("command too early");

  cover property (cmd_valid);
  cover property ($rose(int_n));
  cover property ($fell(event_status[EB_FRAME]));
endmodule

bind status_flag_summary flag_sva chk (
  .clk(clk),
  .resetn(resetn),
  .spi_cs_n(spi_cs_n),
  .spi_so_oe(spi_so_oe),
  .int_n(int_n),
  .sw_reset_req(sw_reset_req),
  .switch_change_event(switch_change_event),
  .supply_cross_event_b(supply_cross_event_b),
  .thermal_shutdown_cond(thermal_shutdown_cond),
  .overvoltage_event(overvoltage_event),
  .event_status(event_status),
  .cmd_valid(cmd_valid)
);
`default_nettype wire

// file: sim/host_spi.sv
// host serial controller model that frames words into the block
`timescale 1ns/1ps
`default_nettype none
module host_spi (
  output logic sclk,
  output logic cs_n,
  output logic si,
  input wire logic so
);
  // serial clock stands low outside frames
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // sends nbits bits of the payload-plus-parity word, wrapping after 32; bad spoils the parity on purpose
  task automatic xfer(input logic [30:0] p, input bit bad,
    input int nbits, output logic [31:0] r);
    logic [31:0] w;
    w = {p, ~^p ^ bad};
    r = '0;
    cs_n = 1'b0;
    #30;
    for (int k = 0; k < nbits; k++) begin
      // data moves mid low phase, away from the sampling fall
      #3 si = w[31 - (k % 32)];
      #3 sclk = 1'b1;
      #6 sclk = 1'b0;
      r = {r[30:0], so};
    end
    #6 cs_n = 1'b1;
    // a released line must not keep showing the last bit
    si = ~si;
    #40;
  endtask
endmodule
`default_nettype wire

// file: sim/tb.sv
// testbench for the status flag summary block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import flag_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic sw_rst = 1'b0;
  logic warn_lvl = 1'b0;
  logic shut_lvl = 1'b0;
  logic [8:0] ev = '0;
  logic [23:0] rdat = 24'h5a_3c71;
  logic sclk, cs_n, si, so, so_oe, int_n, cv, cw;
  logic [EVT_W-1:0] evs;
  logic [ADDR_W-1:0] ca;
  logic [DATA_W-1:0] cd;
  logic [31:0] r;
  logic [6:0] xf [13] = '{7'h08, 7'h04, 7'h04, 7'h01, 7'h01, 7'h01,
    7'h01, 7'h01, 7'h01, 7'h02, 7'h02, 7'h02, 7'h02};
  int lens [3] = '{31, 33, 0};
  int failures = 0;
  int n_compared = 0;
  int n_cmd = 0;
  int c0;

  always #2.5 clk = ~clk;

  status_flag_summary dut (
    .clk(clk), .resetn(resetn), .spi_sclk(sclk), .spi_cs_n(cs_n),
    .spi_si(si), .spi_so(so), .spi_so_oe(so_oe), .int_n(int_n),
    .sw_reset_req(sw_rst), .switch_change_event(ev[0]),
    .supply_cross_event_a(ev[1]), .supply_cross_event_b(ev[2]),
    .thermal_warning_cond(warn_lvl), .thermal_shutdown_cond(shut_lvl),
    .overvoltage_event(ev[3]), .undervoltage_event(ev[4]),
    .checksum_done_event(ev[5]), .wetting_diag_event(ev[6]),
    .converter_diag_event(ev[7]), .integrity_check_fail_event(ev[8]),
    .resp_data(rdat), .event_status(evs), .cmd_valid(cv),
    .cmd_write(cw), .cmd_addr(ca), .cmd_wdata(cd)
  );
  host_spi host (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so));

  // counts accepted words so dropped frames can be seen
  always @(posedge clk) if (cv) n_cmd <= n_cmd + 1;

  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic endt(input string nm);
    $display("test %s done", nm);
  endtask
  // reads the event register, checks response and the clear behind it
  task automatic evt_read(input logic [6:0] ef);
    host.xfer({1'b0, EVT_ADDR, 24'h00_0000}, 1'b0, 32, r);
    chk("flags", {25'h0, ef}, {25'h0, r[31:25]});
    chk("data", {8'h00, rdat}, {8'h00, r[24:1]});
    chk("parity", 32'h0000_0001, {31'h0, ^r});
    chk("cleared", 32'h0000_0000, {18'h0, evs});
    chk("irq released", 32'h0000_0001, {31'h0, int_n});
  endtask
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk);
    #1 resetn = 1'b1;
    cyc(4);
    evt_read(7'h40);
    endt("power up");
    // each source in turn; thermal levels toggle up then down
    for (int i = 0; i < 13; i++) begin
      @(posedge clk);
      #1;
      if (i < 9) ev[i] = 1'b1;
      else if (i < 11) warn_lvl = ~warn_lvl;
      else shut_lvl = ~shut_lvl;
      cyc(1);
      ev = '0;
      cyc(2);
      chk("irq low", 32'h0, {31'h0, int_n});
      evt_read(xf[i]);
    end
    endt("event sources");
    c0 = n_cmd;
    host.xfer({1'b1, 6'h1a, 24'h12_3456}, 1'b0, 32, r);
    chk("write flags", 32'h0, {25'h0, r[31:25]});
    chk("cmd seen", c0 + 1, n_cmd);
    chk("cmd fields", {7'h5a, 24'h12_3456}, {cw, ca, cd});
    endt("good write");
    // short, long and clockless frames
    for (int j = 0; j < 3; j++) begin
      c0 = n_cmd;
      host.xfer({1'b1, 6'h1a, 24'h00_0001}, 1'b0, lens[j], r);
      chk("dropped", c0, n_cmd);
      chk("frame bit", {31'h0, lens[j] != 0},
        {31'h0, evs[EB_FRAME]});
      chk("irq", {31'h0, lens[j] == 0}, {31'h0, int_n});
      if (lens[j] != 0) evt_read(7'h20);
    end
    endt("frame length");
    c0 = n_cmd;
    host.xfer({1'b1, 6'h1a, 24'h00_0003}, 1'b1, 32, r);
    chk("dropped", c0, n_cmd);
    chk("parity bit", 32'h1, {31'h0, evs[EB_PARITY]});
    chk("irq", 32'h0, {31'h0, int_n});
    evt_read(7'h10);
    endt("parity");
    @(posedge clk);
    #1 sw_rst = 1'b1;
    cyc(1);
    sw_rst = 1'b0;
    cyc(2);
    evt_read(7'h40);
    endt("soft reset");
    summarize();
  end

  // cuts a hang short well past the expected run length
  initial begin
    #100000;
    failures++;
    summarize();
  end
endmodule
`default_nettype wire

// file: verilog/flag_pkg.sv
// constants shared by the status flag summary block and its link side
package flag_pkg;
  // frame geometry
  localparam int FRAME_BITS = 32;
  localparam int CNT_W = 6;
  localparam logic [5:0] CNT_ZERO = 6'h00;
  localparam logic [5:0] CNT_FULL = 6'h20;
  localparam logic [5:0] CNT_SAT = 6'h21;
  localparam int RW_BIT = 31;
  localparam int ADDR_HI = 30;
  localparam int ADDR_LO = 25;
  localparam int DATA_HI = 24;
  localparam int DATA_LO = 1;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 24;
  // address of the event status register
  localparam logic [5:0] EVT_ADDR = 6'h02;
  // event status register layout
  localparam int EVT_W = 14;
  localparam int EB_RESET = 0;
  localparam int EB_FRAME = 1;
  localparam int EB_PARITY = 2;
  localparam int EB_SWITCH = 3;
  localparam int EB_THERM_SHUT = 4;
  localparam int EB_THERM_WARN = 5;
  localparam int EB_OVERVOLT = 6;
  localparam int EB_UNDERVOLT = 7;
  localparam int EB_CHECKSUM = 8;
  localparam int EB_SUPPLY_A = 9;
  localparam int EB_SUPPLY_B = 10;
  localparam int EB_WETTING = 11;
  localparam int EB_CONVERTER = 12;
  localparam int EB_INTEGRITY = 13;
  localparam logic [13:0] EVT_RESET_VAL = 14'h0001;
  localparam logic [13:0] EVT_ALL = 14'h3fff;
  localparam logic [13:0] EVT_NONE = 14'h0000;
  // status flags inside the flag vector, vector sits at bits 31..25
  localparam int FLAG_W = 7;
  localparam int FL_RESET = 6;
  localparam int FL_FRAME = 5;
  localparam int FL_PARITY = 4;
  localparam int FL_SWITCH = 3;
  localparam int FL_SUPPLY = 2;
  localparam int FL_THERMAL = 1;
  localparam int FL_OTHER = 0;
  // frame tracking states on the system clock
  typedef enum logic [1:0] {
    FS_IDLE = 2'b00,
    FS_ACTIVE = 2'b01,
    FS_CLOSE = 2'b10
  } frame_state_t;
endpackage

// file: verilog/level_sync.sv
// two flip-flop synchroniser for slow levels entering the system clock
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  // first stage feeds only the second stage
  always_comb begin
    meta_next = d;
    q_next = meta_reg;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      meta_reg <= INIT;
      q_reg <= INIT;
    end else begin
      meta_reg <= meta_next;
      q_reg <= q_next;
    end
  end

  assign q = q_reg;
endmodule
`default_nettype wire

// file: verilog/link_shift.sv
// serial-clock side shift registers: word capture, bit count, response
`timescale 1ns/1ps
`default_nettype none
module link_shift
  import flag_pkg::*;
(
  input wire logic sclk,
  input wire logic link_clr,
  input wire logic si,
  input wire logic [31:0] resp_word,
  output logic so,
  output logic [31:0] rx_word,
  output logic [5:0] rx_cnt
);
  logic [31:0] rx_word_reg;
  logic [31:0] rx_word_next;
  logic [5:0] rx_cnt_reg;
  logic [5:0] rx_cnt_next;
  logic [31:0] tx_sh_reg;
  logic [31:0] tx_sh_next;
  logic so_reg;
  logic so_next;
  logic first_reg;
  logic first_next;

  // capture on the falling edge, count saturates so long frames stay bad
  always_comb begin
    rx_word_next = {rx_word_reg[30:0], si};
    rx_cnt_next = rx_cnt_reg;
    if (rx_cnt_reg != CNT_SAT) begin
      rx_cnt_next = rx_cnt_reg + 6'h01;
    end
  end

  // clear is asynchronous because the serial clock stops between frames
  always_ff @(negedge sclk or posedge link_clr) begin
    if (link_clr) begin
      rx_word_reg <= 32'h0000_0000;
      rx_cnt_reg <= CNT_ZERO;
    end else begin
      rx_word_reg <= rx_word_next;
      rx_cnt_reg <= rx_cnt_next;
    end
  end

  // first rising edge loads the frozen snapshot, msb first
  always_comb begin
    first_next = 1'b0;
    if (first_reg) begin
      so_next = resp_word[31]; // RL18
      tx_sh_next = {resp_word[30:0], 1'b0};
    end else begin
      so_next = tx_sh_reg[31]; // RL18
      tx_sh_next = {tx_sh_reg[30:0], 1'b0};
    end
  end

  // output idles high so the pin reads high right after the select edge
  always_ff @(posedge sclk or posedge link_clr) begin
    if (link_clr) begin
      so_reg <= 1'b1;
      tx_sh_reg <= 32'h0000_0000;
      first_reg <= 1'b1;
    end else begin
      so_reg <= so_next;
      tx_sh_reg <= tx_sh_next;
      first_reg <= first_next;
    end
  end

  assign so = so_reg;
  assign rx_word = rx_word_reg;
  assign rx_cnt = rx_cnt_reg;
endmodule
`default_nettype wire

// file: verilog/status_flag_summary.sv
// event status register, status flag summary and serial frame checking
// Behaviour
// RL1 - status flags go out on the serial output in every read and write
// RL2 - flags hold no state, they are formed from the event register
// RL3 - reading the event register clears it and hence every flag
// RL4 - that clear happens at the select rising edge ending the read
// RL5 - reset flag reads one after any reset until the register is read
// RL6 - frames other than 32 bits set frame error, pull interrupt, drop word
// RL7 - a select pulse without serial clock edges is no frame error
// RL8 - each 32-bit word including parity must hold an odd count of ones
// RL9 - an even count of ones drops the word, sets parity error, pulls irq
// RL10 - switch flag mirrors the switch change event bit
// RL11 - supply flag is the or of both supply crossing event bits
// RL12 - thermal flag is the or of thermal warning and shutdown bits
// RL13 - thermal bits set both when a condition begins and when it ends
// RL14 - other flag ors overvoltage, undervoltage, checksum, diag bits
// RL15 - the host reads the event register to find which event was raised
// RL16 - select falling edge enables output and freezes an event snapshot
// RL17 - interrupt released high at select rise ending an event read
// RL18 - flags are shifted out first, msb first, before data and parity
// RL19 - bits 31..25 hold reset, frame, parity, switch, supply, thermal, other
`timescale 1ns/1ps
`default_nettype none
module status_flag_summary
  import flag_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_si,
  output logic spi_so,
  output logic spi_so_oe,
  output logic int_n,
  input wire logic sw_reset_req,
  input wire logic switch_change_event,
  input wire logic supply_cross_event_a,
  input wire logic supply_cross_event_b,
  input wire logic thermal_warning_cond,
  input wire logic thermal_shutdown_cond,
  input wire logic overvoltage_event,
  input wire logic undervoltage_event,
  input wire logic checksum_done_event,
  input wire logic wetting_diag_event,
  input wire logic converter_diag_event,
  input wire logic integrity_check_fail_event,
  input wire logic [DATA_W-1:0] resp_data,
  output logic [EVT_W-1:0] event_status,
  output logic cmd_valid,
  output logic cmd_write,
  output logic [ADDR_W-1:0] cmd_addr,
  output logic [DATA_W-1:0] cmd_wdata
);
  frame_state_t state_reg;
  frame_state_t state_next;
  logic cs_sync;
  logic link_clr_reg;
  logic link_clr_next;
  logic link_clr;
  logic [31:0] rx_word;
  logic [5:0] rx_cnt;
  logic [EVT_W-1:0] event_reg;
  logic [EVT_W-1:0] event_next;
  logic [EVT_W-1:0] evt_set;
  logic [EVT_W-1:0] evt_clr;
  logic [FLAG_W-1:0] flags;
  logic [31:0] shadow_reg;
  logic [31:0] shadow_next;
  logic [DATA_W-1:0] resp_body;
  logic warn_prev_reg;
  logic warn_prev_next;
  logic shut_prev_reg;
  logic shut_prev_next;
  logic int_n_reg;
  logic int_n_next;
  logic cmd_valid_reg;
  logic cmd_valid_next;
  logic cmd_write_reg;
  logic cmd_write_next;
  logic [ADDR_W-1:0] cmd_addr_reg;
  logic [ADDR_W-1:0] cmd_addr_next;
  logic [DATA_W-1:0] cmd_wdata_reg;
  logic [DATA_W-1:0] cmd_wdata_next;
  logic closing;
  logic frame_bad;
  logic parity_bad;
  logic word_good;
  logic evt_read;

  // chip select is a pin, so it is synchronised before the frame tracking decisions
  level_sync #(
    .W(1),
    .INIT(1'b1)
  ) u_cs_sync (
    .clk(clk),
    .resetn(resetn),
    .d(spi_cs_n),
    .q(cs_sync)
  );

  // link logic is held clear only while select is high; a falling select
  // releases it at once, before the first serial clock edge can arrive
  assign link_clr = (link_clr_reg | ~resetn) & spi_cs_n;

  // the snapshot lives on the system clock; the link only reads it frozen
  link_shift u_link (
    .sclk(spi_sclk),
    .link_clr(link_clr),
    .si(spi_si),
    .resp_word(shadow_reg),
    .so(spi_so),
    .rx_word(rx_word),
    .rx_cnt(rx_cnt)
  );

  // output driver follows select directly; no clock runs at that edge
  assign spi_so_oe = ~spi_cs_n; // RL16

  // frame tracking: idle, select low, one cycle to judge the frame
  always_comb begin
    state_next = state_reg;
    link_clr_next = 1'b0;
    case (state_reg)
      FS_IDLE: begin
        link_clr_next = 1'b1;
        if (!cs_sync) begin
          state_next = FS_ACTIVE;
          link_clr_next = 1'b0;
        end
      end
      FS_ACTIVE: begin
        if (cs_sync) begin
          state_next = FS_CLOSE;
        end
      end
      FS_CLOSE: begin
        state_next = FS_IDLE;
        link_clr_next = 1'b1;
      end
      default: begin
        state_next = FS_IDLE;
        link_clr_next = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_reg <= FS_IDLE;
      link_clr_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      link_clr_reg <= link_clr_next;
    end
  end

  // link words are static once select is high, so reading them here
  // after the synchronised rising edge is a safe quasi-static crossing
  assign closing = (state_reg == FS_CLOSE);
  assign frame_bad = closing && (rx_cnt != CNT_ZERO) &&
                     (rx_cnt != CNT_FULL); // RL6 RL7
  assign parity_bad = closing && (rx_cnt == CNT_FULL) &&
                      !(^rx_word); // RL8 RL9
  assign word_good = closing && (rx_cnt == CNT_FULL) && (^rx_word);
  assign evt_read = word_good && !rx_word[RW_BIT] &&
                    (rx_word[ADDR_HI:ADDR_LO] == EVT_ADDR); // RL3 RL4

  // summary flags: pure gating of the event register, no storage
  always_comb begin
    flags = '0;
    flags[FL_RESET] = event_reg[EB_RESET]; // RL2 RL5
    flags[FL_FRAME] = event_reg[EB_FRAME]; // RL2
    flags[FL_PARITY] = event_reg[EB_PARITY]; // RL2
    flags[FL_SWITCH] = event_reg[EB_SWITCH]; // RL10
    flags[FL_SUPPLY] = event_reg[EB_SUPPLY_A] |
                       event_reg[EB_SUPPLY_B]; // RL11
    flags[FL_THERMAL] = event_reg[EB_THERM_WARN] |
                        event_reg[EB_THERM_SHUT]; // RL12
    flags[FL_OTHER] = event_reg[EB_OVERVOLT] | event_reg[EB_UNDERVOLT] |
                      event_reg[EB_CHECKSUM] | event_reg[EB_WETTING] |
                      event_reg[EB_CONVERTER] |
                      event_reg[EB_INTEGRITY]; // RL14
  end

  // thermal conditions are levels; both edges raise the event
  always_comb begin
    warn_prev_next = thermal_warning_cond;
    shut_prev_next = thermal_shutdown_cond;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      warn_prev_reg <= 1'b0;
      shut_prev_reg <= 1'b0;
    end else begin
      warn_prev_reg <= warn_prev_next;
      shut_prev_reg <= shut_prev_next;
    end
  end

  // event register: sets always beat the read clear of the same cycle
  always_comb begin
    evt_set = EVT_NONE;
    evt_set[EB_RESET] = sw_reset_req; // RL5
    evt_set[EB_FRAME] = frame_bad; // RL6
    evt_set[EB_PARITY] = parity_bad; // RL9
    evt_set[EB_SWITCH] = switch_change_event; // RL10
    evt_set[EB_THERM_WARN] = thermal_warning_cond ^ warn_prev_reg; // RL13
    evt_set[EB_THERM_SHUT] = thermal_shutdown_cond ^ shut_prev_reg; // RL13
    evt_set[EB_OVERVOLT] = overvoltage_event;
    evt_set[EB_UNDERVOLT] = undervoltage_event;
    evt_set[EB_CHECKSUM] = checksum_done_event;
    evt_set[EB_SUPPLY_A] = supply_cross_event_a;
    evt_set[EB_SUPPLY_B] = supply_cross_event_b;
    evt_set[EB_WETTING] = wetting_diag_event;
    evt_set[EB_CONVERTER] = converter_diag_event;
    evt_set[EB_INTEGRITY] = integrity_check_fail_event;
    evt_clr = evt_read ? EVT_ALL : EVT_NONE; // RL3 RL4
    event_next = (event_reg & ~evt_clr) | evt_set;
  end

  // hardware reset leaves only the reset flag standing
  always_ff @(posedge clk) begin
    if (!resetn) begin
      event_reg <= EVT_RESET_VAL; // RL5
    end else begin
      event_reg <= event_next;
    end
  end

  // interrupt: pulled low by any new non-reset event, released by an event register read;
  // reset alone does not pull it so power-up stays quiet
  always_comb begin
    int_n_next = int_n_reg;
    if (evt_read) begin
      int_n_next = 1'b1; // RL17
    end
    if (|(evt_set & ~EVT_RESET_VAL)) begin
      int_n_next = 1'b0; // RL6 RL9
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      int_n_reg <= 1'b1;
    end else begin
      int_n_reg <= int_n_next;
    end
  end

  // snapshot follows the flags while idle and freezes once select falls;
  // the host must leave a short lead time so the freeze lands first
  always_comb begin
    resp_body = resp_data;
    shadow_next = shadow_reg;
    if (state_reg == FS_IDLE && cs_sync) begin
      shadow_next = {flags, resp_body, ~(^{flags, resp_body})}; // RL1 RL19
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      shadow_reg <= 32'h0000_0000;
    end else begin
      shadow_reg <= shadow_next; // RL16
    end
  end

  // a good word is handed on as a one-cycle command; bad ones are dropped
  always_comb begin
    cmd_valid_next = word_good; // RL6 RL9
    cmd_write_next = cmd_write_reg;
    cmd_addr_next = cmd_addr_reg;
    cmd_wdata_next = cmd_wdata_reg;
    if (word_good) begin
      cmd_write_next = rx_word[RW_BIT];
      cmd_addr_next = rx_word[ADDR_HI:ADDR_LO];
      cmd_wdata_next = rx_word[DATA_HI:DATA_LO];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cmd_valid_reg <= 1'b0;
      cmd_write_reg <= 1'b0;
      cmd_addr_reg <= '0;
      cmd_wdata_reg <= '0;
    end else begin
      cmd_valid_reg <= cmd_valid_next;
      cmd_write_reg <= cmd_write_next;
      cmd_addr_reg <= cmd_addr_next;
      cmd_wdata_reg <= cmd_wdata_next;
    end
  end

  assign int_n = int_n_reg;
  assign event_status = event_reg;
  assign cmd_valid = cmd_valid_reg;
  assign cmd_write = cmd_write_reg;
  assign cmd_addr = cmd_addr_reg;
  assign cmd_wdata = cmd_wdata_reg;
endmodule
`default_nettype wire
